// ---- common/mra_pkg.sv ----
// Shared constants, encodings and types for the region attribute resolver
package mra_pkg;
    localparam int ADDR_W       = 32;
    localparam int NUM_REGIONS  = 16;
    localparam int SCW_W        = 32;
    localparam int SCW_MPU_EN   = 0;
    localparam int SCW_BRE_BIT  = 17;
    localparam int TEX_CACHE    = 2;
    localparam int DEFMAP_DEV   = 31;
    localparam int SUB_LOG2     = 3;

    localparam logic [4:0] SIZE_MIN  = 5'h07;
    localparam logic [4:0] SIZE_FULL = 5'h1F;

    // Five-bit type code is {type_extension_field, c, b}
    localparam logic [4:0] CODE_SO      = 5'h00;
    localparam logic [4:0] CODE_SH_DEV  = 5'h01;
    localparam logic [4:0] CODE_NORM_NC = 5'h04;
    localparam logic [4:0] CODE_NORM_WB = 5'h07;
    localparam logic [4:0] CODE_NS_DEV  = 5'h08;

    localparam logic [1:0] POL_NC   = 2'h0;
    localparam logic [1:0] POL_WBWA = 2'h1;
    localparam logic [1:0] POL_RSVD = 2'h2;

    localparam logic [3:0] CACHE_SO   = 4'h0;
    localparam logic [3:0] CACHE_DEV  = 4'h1;
    localparam logic [3:0] CACHE_NC   = 4'h3;
    localparam logic [3:0] CACHE_WBWA = 4'hF;

    typedef enum logic [1:0] {
        MRA_SO,
        MRA_DEV,
        MRA_NORMAL
    } mra_mtype_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] base;
        logic [4:0]        size;
        logic [7:0]        srd;
        logic [2:0]        type_extension_field;
        logic              c;
        logic              b;
        logic              s;
        logic [2:0]        ap;
        logic              xn;
    } mra_region_t;

    localparam int REGION_W = $bits(mra_region_t);

    typedef struct packed {
        mra_mtype_t mtype;
        logic       share;
        logic [1:0] inner;
        logic [1:0] outer;
    } mra_attr_t;
endpackage

// ---- common/mra_match_if.sv ----
// Carrier between the resolver and one region matcher
`timescale 1ns/1ps
interface mra_match_if;
    logic [mra_pkg::ADDR_W-1:0] addr;
    mra_pkg::mra_region_t       cfg;
    logic                       hit;

    modport drv (output addr, output cfg, input hit);
    modport mat (input addr, input cfg, output hit);
endinterface

// ---- core/mra_region_match.sv ----
// Single region address and subregion match
`timescale 1ns/1ps
module mra_region_match (
    mra_match_if.mat m
);
    import mra_pkg::*;

    logic [ADDR_W-1:0] span_mask;
    logic [ADDR_W-1:0] base_diff;
    logic [4:0]        sub_shift;
    logic [2:0]        sub_idx;
    logic              base_ok;
    logic              sub_dis;

    // Region of code n spans 2^(n+1) bytes; full code has no base bits left
    assign span_mask = (m.cfg.size == SIZE_FULL) ? '1 :
                       ((32'h1 << ({1'b0, m.cfg.size} + 6'h01)) - 32'h1);
    assign base_diff = (m.addr ^ m.cfg.base) & ~span_mask;
    assign base_ok   = (base_diff == '0);
    // Top three offset bits pick the eighth
    assign sub_shift = m.cfg.size - 5'(SUB_LOG2 - 1);
    assign sub_idx   = 3'(m.addr >> sub_shift);
    assign sub_dis   = m.cfg.srd[sub_idx];
    // Sizes below the minimum are unusable and never match
    assign m.hit     = m.cfg.en && (m.cfg.size >= SIZE_MIN) && base_ok && !sub_dis;
endmodule

// ---- core/mra_resolver.sv ----
// Protection region attribute resolver for load/store and fetch accesses
// Behaviour
// - eight-bit subregion disable; bit n masks eighth n
// - write into disabled subregion, uncovered, faults
// - address matching no region faults by default
// - full-span region 0 serves otherwise unmatched addresses
// - background enable lets privileged misses use default map
// - unprivileged misses still fault under background enable
// - TCM addresses forced Normal, Non-shareable
// - TCM permissions still from covering region
// - Strongly Ordered is in order and shareable
// - Device/SO reads drain Device/SO buffered writes first
// - interrupt latency may stretch during Device/SO access
// - type decoded from extension field plus two bits
// - codes for Strongly Ordered and both Device kinds
// - code 001/00 is Normal, non-cacheable both levels
// - code 001/11 is Normal, write-back allocate both
// - Normal shareability follows region share flag
// - top extension bit set gives Normal, inner policy from c/b, outer from low extension bits
// - policy codes 00 none, 01 write-back, 10 reserved
// - inner on user sideband, outer on cache signals
// - highest-numbered matching region wins
// - disabled subregion falls through to lower regions
`timescale 1ns/1ps
module mra_resolver #(
    parameter int NUM_REGIONS = mra_pkg::NUM_REGIONS
) (
    input  wire logic                                       clk_sys,
    input  wire logic                                       sys_rst,
    input  wire logic                                       req_valid,
    output wire logic                                       req_ready,
    input  wire logic [mra_pkg::ADDR_W-1:0]                 req_addr,
    input  wire logic                                       req_write,
    input  wire logic                                       req_priv,
    input  wire logic                                       req_fetch,
    input  wire logic [NUM_REGIONS*mra_pkg::REGION_W-1:0]   region_cfg,
    input  wire logic [mra_pkg::SCW_W-1:0]                  system_control_word,
    input  wire logic                                       tcm_enable,
    input  wire logic [mra_pkg::ADDR_W-1:0]                 tcm_base,
    input  wire logic [mra_pkg::ADDR_W-1:0]                 tcm_mask,
    input  wire logic                                       sb_dev_wr_pending,
    output wire logic                                       resp_valid,
    output wire logic                                       resp_fault_bg,
    output wire logic                                       resp_hit,
    output wire logic [$clog2(NUM_REGIONS)-1:0]             resp_region,
    output wire logic                                       resp_default_map,
    output wire logic                                       resp_tcm,
    output wire logic                                       resp_fetch,
    output wire logic [1:0]                                 resp_mem_type,
    output wire logic                                       resp_shareable,
    output wire logic [1:0]                                 resp_inner_pol,
    output wire logic [1:0]                                 resp_outer_pol,
    output wire logic [2:0]                                 resp_ap,
    output wire logic                                       resp_xn,
    output wire logic                                       resp_in_order,
    output wire logic [4:0]                                 bus_inner_attr_sideband,
    output wire logic [3:0]                                 bus_outer_attr_signals,
    output wire logic                                       drain_req,
    output wire logic                                       irq_latency_ext
);
    import mra_pkg::*;

    localparam int IDX_W = $clog2(NUM_REGIONS);

    typedef enum logic {
        MRA_IDLE,
        MRA_DRAIN
    } mra_state_t;

    typedef struct packed {
        logic             fault;
        logic             hit;
        logic [IDX_W-1:0] region;
        logic             defmap;
        logic             tcm;
        logic             fetch;
        mra_attr_t        attr;
        logic [2:0]       ap;
        logic             xn;
        logic [4:0]       user;
        logic [3:0]       cache;
        logic             in_order;
    } mra_res_t;

    // Reserved policy codes fall back to non-cacheable
    function automatic logic [1:0] mra_pol_fix(input logic [1:0] pol);
        logic [1:0] r;
        r = (pol == POL_WBWA) ? POL_WBWA : POL_NC;
        return r;
    endfunction

    function automatic mra_attr_t mra_decode(
        input logic [2:0] type_extension_field,
        input logic       c,
        input logic       b,
        input logic       s
    );
        mra_attr_t a;
        // Unlisted codes resolve as Strongly Ordered: slowest but never wrong in ordering
        a.mtype = MRA_SO;
        a.share = 1'b1;
        a.inner = POL_NC;
        a.outer = POL_NC;
        if (type_extension_field[TEX_CACHE]) begin
            a.mtype = MRA_NORMAL;
            a.share = s;
            a.inner = mra_pol_fix({c, b});
            a.outer = mra_pol_fix(type_extension_field[1:0]);
        end else begin
            case ({type_extension_field, c, b})
                CODE_SO: begin
                    a.mtype = MRA_SO;
                    a.share = 1'b1;
                end
                CODE_SH_DEV: begin
                    a.mtype = MRA_DEV;
                    a.share = 1'b1;
                end
                CODE_NS_DEV: begin
                    a.mtype = MRA_DEV;
                    a.share = 1'b0;
                end
                CODE_NORM_NC: begin
                    a.mtype = MRA_NORMAL;
                    a.share = s;
                end
                CODE_NORM_WB: begin
                    a.mtype = MRA_NORMAL;
                    a.share = s;
                    a.inner = POL_WBWA;
                    a.outer = POL_WBWA;
                end
                default: begin
                    a.mtype = MRA_SO;
                    a.share = 1'b1;
                end
            endcase
        end
        return a;
    endfunction

    mra_region_t      cfg_a [NUM_REGIONS];
    logic [NUM_REGIONS-1:0] hit_v;
    logic             win_hit;
    logic [IDX_W-1:0] win_idx;
    mra_region_t      win_cfg;
    mra_attr_t        reg_attr;
    mra_attr_t        def_attr;
    mra_attr_t        sel_attr;
    mra_attr_t        fin_attr;
    logic             mpu_on;
    logic             bre_on;
    logic             use_defmap;
    logic             bg_fault;
    logic             tcm_hit;
    logic             slow_type;
    logic             needs_drain;
    logic             accept;
    logic [3:0]       cache_code;
    logic [4:0]       user_code;
    mra_res_t         res_now;

    mra_state_t       state_r;
    mra_state_t       state_nxt;
    mra_res_t         res_r;
    mra_res_t         res_nxt;
    logic             ready_r;
    logic             ready_nxt;
    logic             valid_r;
    logic             valid_nxt;
    logic             drain_r;
    logic             drain_nxt;
    logic             irq_ext_r;
    logic             irq_ext_nxt;

    // One matcher per region, all looking at the same address in the same cycle
    for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
        mra_match_if m_if ();
        assign cfg_a[g]   = region_cfg[g*REGION_W +: REGION_W];
        assign m_if.addr  = req_addr;
        assign m_if.cfg   = cfg_a[g];
        assign hit_v[g]   = m_if.hit;
        mra_region_match u_match (
            .m (m_if.mat)
        );
    end

    // Ascending scan: a later hit overwrites, so the highest index wins
    always_comb begin
        win_hit = 1'b0;
        win_idx = '0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (hit_v[i]) begin
                win_hit = 1'b1;
                win_idx = IDX_W'(i);
            end
        end
    end

    // A full-span region 0 hits every address, so it only wins when nothing else does
    assign win_cfg    = cfg_a[win_idx];
    assign reg_attr   = mra_decode(win_cfg.type_extension_field, win_cfg.c, win_cfg.b, win_cfg.s);

    assign mpu_on     = system_control_word[SCW_MPU_EN];
    assign bre_on     = system_control_word[SCW_BRE_BIT];
    // Disabled subregions already dropped out of hit_v, so lower regions, the default map or the fault take over
    assign bg_fault   = mpu_on && !win_hit && !(bre_on && req_priv);
    assign use_defmap = !mpu_on || (!win_hit && bre_on && req_priv);

    // Default map kept coarse: upper half peripherals, lower half plain memory
    assign def_attr.mtype = req_addr[DEFMAP_DEV] ? MRA_DEV : MRA_NORMAL;
    assign def_attr.share = req_addr[DEFMAP_DEV];
    assign def_attr.inner = POL_NC;
    assign def_attr.outer = POL_NC;
    assign sel_attr   = use_defmap ? def_attr : reg_attr;

    assign tcm_hit    = tcm_enable && (((req_addr ^ tcm_base) & ~tcm_mask) == '0);
    assign fin_attr.mtype = tcm_hit ? MRA_NORMAL : sel_attr.mtype;
    assign fin_attr.share = tcm_hit ? 1'b0 : sel_attr.share;
    assign fin_attr.inner = tcm_hit ? POL_NC : sel_attr.inner;
    assign fin_attr.outer = tcm_hit ? POL_NC : sel_attr.outer;

    assign cache_code = (fin_attr.mtype == MRA_SO)  ? CACHE_SO :
                        (fin_attr.mtype == MRA_DEV) ? CACHE_DEV :
                        (fin_attr.outer == POL_WBWA) ? CACHE_WBWA : CACHE_NC;
    assign user_code  = {fin_attr.share, fin_attr.mtype, fin_attr.inner};

    assign res_now.fault  = bg_fault;
    assign res_now.hit    = win_hit;
    assign res_now.region = win_idx;
    assign res_now.defmap = use_defmap;
    assign res_now.tcm    = tcm_hit;
    assign res_now.fetch  = req_fetch;
    assign res_now.attr   = fin_attr;
    // Permissions stay with the region even where TCM rewrites the type
    assign res_now.ap     = win_cfg.ap;
    assign res_now.xn     = win_cfg.xn;
    assign res_now.user   = user_code;
    assign res_now.cache  = cache_code;
    assign res_now.in_order = (fin_attr.mtype == MRA_SO);

    assign slow_type   = !bg_fault && (fin_attr.mtype != MRA_NORMAL);
    // Only reads wait; writes queue behind the buffered ones anyway
    assign needs_drain = slow_type && !req_write && sb_dev_wr_pending;
    assign accept      = req_valid && ready_r;

    always_comb begin
        state_nxt   = state_r;
        res_nxt     = res_r;
        ready_nxt   = ready_r;
        valid_nxt   = 1'b0;
        drain_nxt   = drain_r;
        irq_ext_nxt = 1'b0;
        case (state_r)
            MRA_IDLE: begin
                if (accept) begin
                    res_nxt     = res_now;
                    irq_ext_nxt = slow_type;
                    if (needs_drain) begin
                        state_nxt = MRA_DRAIN;
                        ready_nxt = 1'b0;
                        drain_nxt = 1'b1;
                    end else begin
                        valid_nxt = 1'b1;
                    end
                end
            end
            MRA_DRAIN: begin
                irq_ext_nxt = 1'b1;
                if (!sb_dev_wr_pending) begin
                    state_nxt = MRA_IDLE;
                    ready_nxt = 1'b1;
                    drain_nxt = 1'b0;
                    valid_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = MRA_IDLE;
                ready_nxt = 1'b1;
                drain_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r   <= MRA_IDLE;
            res_r     <= '0;
            ready_r   <= 1'b0;
            valid_r   <= 1'b0;
            drain_r   <= 1'b0;
            irq_ext_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            res_r     <= res_nxt;
            ready_r   <= ready_nxt || (state_r == MRA_IDLE && !accept);
            valid_r   <= valid_nxt;
            drain_r   <= drain_nxt;
            irq_ext_r <= irq_ext_nxt;
        end
    end

    assign req_ready               = ready_r;
    assign resp_valid              = valid_r;
    assign resp_fault_bg           = res_r.fault;
    assign resp_hit                = res_r.hit;
    assign resp_region             = res_r.region;
    assign resp_default_map        = res_r.defmap;
    assign resp_tcm                = res_r.tcm;
    assign resp_fetch              = res_r.fetch;
    assign resp_mem_type           = res_r.attr.mtype;
    assign resp_shareable          = res_r.attr.share;
    assign resp_inner_pol          = res_r.attr.inner;
    assign resp_outer_pol          = res_r.attr.outer;
    assign resp_ap                 = res_r.ap;
    assign resp_xn                 = res_r.xn;
    // Strongly Ordered accesses must leave in program order
    assign resp_in_order           = res_r.in_order;
    assign bus_inner_attr_sideband = res_r.user;
    assign bus_outer_attr_signals  = res_r.cache;
    assign drain_req               = drain_r;
    assign irq_latency_ext         = irq_ext_r;
endmodule

// ---- tb/mra_resolver_monitor.sv ----
// Concurrent checks on the resolver top-level ports
`timescale 1ns/1ps
module mra_resolver_monitor (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_write,
    input wire logic       sb_dev_wr_pending,
    input wire logic       resp_valid,
    input wire logic       resp_fault_bg,
    input wire logic       resp_hit,
    input wire logic       resp_default_map,
    input wire logic       resp_tcm,
    input wire logic [1:0] resp_mem_type,
    input wire logic       resp_shareable,
    input wire logic [1:0] resp_inner_pol,
    input wire logic [1:0] resp_outer_pol,
    input wire logic       resp_in_order,
    input wire logic [4:0] bus_inner_attr_sideband,
    input wire logic [3:0] bus_outer_attr_signals,
    input wire logic       drain_req,
    input wire logic       irq_latency_ext
);
    import mra_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_drain_block;
        drain_req |-> !req_ready && !resp_valid;
    endproperty
    a_drain_block: assert property (p_drain_block) else $error("busy while draining");
    property p_drain_exit;
        drain_req && !sb_dev_wr_pending |=> resp_valid && !drain_req && req_ready;
    endproperty
    a_drain_exit: assert property (p_drain_exit) else $error("no answer after drain");
    property p_drain_irq;
        drain_req |-> irq_latency_ext;
    endproperty
    a_drain_irq: assert property (p_drain_irq) else $error("latency flag low");
    property p_no_drain_resp;
        req_valid && req_ready && (req_write || !sb_dev_wr_pending) |=> resp_valid && !drain_req;
    endproperty
    a_no_drain_resp: assert property (p_no_drain_resp) else $error("late answer");
    property p_so_order;
        resp_valid && !resp_fault_bg && resp_mem_type == 2'h0 |-> resp_in_order && resp_shareable;
    endproperty
    a_so_order: assert property (p_so_order) else $error("ordered access not shared");
    property p_sideband;
        resp_valid && !resp_fault_bg |-> bus_inner_attr_sideband == {resp_shareable, resp_mem_type, resp_inner_pol};
    endproperty
    a_sideband: assert property (p_sideband) else $error("bad inner sideband");
    property p_outer;
        resp_valid && !resp_fault_bg && resp_mem_type == 2'h2 && resp_outer_pol == POL_WBWA
            |-> bus_outer_attr_signals == CACHE_WBWA;
    endproperty
    a_outer: assert property (p_outer) else $error("bad outer signals");
    property p_tcm;
        resp_valid && !resp_fault_bg && resp_tcm |-> resp_mem_type == 2'h2 && !resp_shareable;
    endproperty
    a_tcm: assert property (p_tcm) else $error("bad TCM type");
    property p_fault;
        resp_valid && resp_fault_bg |-> !resp_hit && !resp_default_map;
    endproperty
    a_fault: assert property (p_fault) else $error("fault with hit");
    property p_rsvd_pol;
        resp_valid |-> resp_inner_pol != POL_RSVD && resp_outer_pol != POL_RSVD;
    endproperty
    a_rsvd_pol: assert property (p_rsvd_pol) else $error("reserved policy out");
endmodule

bind mra_resolver mra_resolver_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .sb_dev_wr_pending(sb_dev_wr_pending), .resp_valid(resp_valid),
    .resp_fault_bg(resp_fault_bg), .resp_hit(resp_hit), .resp_default_map(resp_default_map), .resp_tcm(resp_tcm),
    .resp_mem_type(resp_mem_type), .resp_shareable(resp_shareable), .resp_inner_pol(resp_inner_pol),
    .resp_outer_pol(resp_outer_pol), .resp_in_order(resp_in_order),
    .bus_inner_attr_sideband(bus_inner_attr_sideband), .bus_outer_attr_signals(bus_outer_attr_signals),
    .drain_req(drain_req), .irq_latency_ext(irq_latency_ext));

// ---- tb/mra_core_model.sv ----
// Pipeline and store buffer model that issues accesses to the resolver
`timescale 1ns/1ps
module mra_core_model (
    input  wire logic   clk_sys,
    input  wire logic   req_ready,
    input  wire logic   resp_valid,
    output logic        req_valid,
    output logic [31:0] req_addr,
    output logic        req_write,
    output logic        req_priv,
    output logic        req_fetch,
    output logic        sb_dev_wr_pending
);
    initial begin
        {req_valid, req_write, req_priv, req_fetch, sb_dev_wr_pending} = '0;
        req_addr = '0;
    end

    // Released fields show the inverse so a stale sample cannot look right
    task automatic access(input logic [31:0] a, input logic wr, input logic pv, input logic fe,
                          input int pend, output logic ok);
        int n;
        n = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr <= a;
        req_write <= wr;
        req_priv <= pv;
        req_fetch <= fe;
        sb_dev_wr_pending <= (pend != 0);
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_write <= ~wr;
        req_priv <= ~pv;
        req_fetch <= ~fe;
        ok = 1'b0;
        for (n = 0; n <= pend + 4 && !ok; n++) begin
            if (n == pend) sb_dev_wr_pending <= 1'b0;
            @(posedge clk_sys);
            ok = (resp_valid === 1'b1);
        end
        sb_dev_wr_pending <= 1'b0;
    endtask
endmodule

// ---- tb/tb_mra_resolver.sv ----
// Directed testbench for the region attribute resolver
`timescale 1ns/1ps
module tb_mra_resolver;
    import mra_pkg::*;
    logic                            clk_sys = 1'b0;
    logic                            sys_rst = 1'b1;
    logic                            req_valid, req_ready, req_write, req_priv, req_fetch, sb_dev_wr_pending;
    logic [ADDR_W-1:0]               req_addr;
    logic [NUM_REGIONS*REGION_W-1:0] region_cfg = '0;
    logic [SCW_W-1:0]                scw = 32'h0000_0001;
    logic                            tcm_enable = 1'b0;
    logic [ADDR_W-1:0]               tcm_base = 32'h0000_2000;
    logic [ADDR_W-1:0]               tcm_mask = 32'h0000_00FF;
    logic                            resp_valid, resp_fault_bg, resp_hit, resp_default_map, resp_tcm, resp_fetch;
    logic [3:0]                      resp_region;
    logic [1:0]                      resp_mem_type, resp_inner_pol, resp_outer_pol;
    logic                            resp_shareable, resp_xn, resp_in_order, drain_req, irq_latency_ext;
    logic [2:0]                      resp_ap;
    logic [4:0]                      bus_inner_attr_sideband;
    logic [3:0]                      bus_outer_attr_signals;
    logic [4:0]                      codes [8];
    logic [6:0]                      exps [8];
    int                              n_fail = 0;
    int                              check_count = 0;

    always #50 clk_sys = ~clk_sys;

    mra_resolver uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_addr(req_addr), .req_write(req_write), .req_priv(req_priv), .req_fetch(req_fetch),
        .region_cfg(region_cfg), .system_control_word(scw), .tcm_enable(tcm_enable), .tcm_base(tcm_base),
        .tcm_mask(tcm_mask), .sb_dev_wr_pending(sb_dev_wr_pending), .resp_valid(resp_valid),
        .resp_fault_bg(resp_fault_bg), .resp_hit(resp_hit), .resp_region(resp_region),
        .resp_default_map(resp_default_map), .resp_tcm(resp_tcm), .resp_fetch(resp_fetch),
        .resp_mem_type(resp_mem_type), .resp_shareable(resp_shareable), .resp_inner_pol(resp_inner_pol),
        .resp_outer_pol(resp_outer_pol), .resp_ap(resp_ap), .resp_xn(resp_xn), .resp_in_order(resp_in_order),
        .bus_inner_attr_sideband(bus_inner_attr_sideband), .bus_outer_attr_signals(bus_outer_attr_signals),
        .drain_req(drain_req), .irq_latency_ext(irq_latency_ext));

    mra_core_model core (.clk_sys(clk_sys), .req_ready(req_ready), .resp_valid(resp_valid), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write), .req_priv(req_priv), .req_fetch(req_fetch),
        .sb_dev_wr_pending(sb_dev_wr_pending));

    task automatic print_verdict;
        $display("Checks made: %0d, mismatches: %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    function automatic mra_region_t mk(input logic [31:0] base, input logic [4:0] size, input logic [7:0] srd,
                                       input logic [4:0] code, input logic s);
        mk = '{en: 1'b1, base: base, size: size, srd: srd, type_extension_field: code[4:2], c: code[1], b: code[0], s: s,
               ap: 3'h5, xn: 1'b1};
    endfunction

    task automatic set_reg(input int g, input mra_region_t r);
        @(posedge clk_sys);
        region_cfg[g*REGION_W +: REGION_W] <= r;
    endtask

    // Expected attributes e packed as {mem_type, shareable, inner, outer}
    task automatic acc(input logic [31:0] a, input logic wr, input logic pv, input int pend, input logic flt,
                       input logic dm, input logic [3:0] rg, input logic [6:0] e);
        logic ok;
        core.access(a, wr, pv, pv, pend, ok);
        check(ok, 1'b1);
        check(resp_fault_bg, flt);
        check(resp_hit, !dm && !flt);
        check(resp_fetch, pv);
        if (!flt) begin
            check(resp_default_map, dm);
            check(resp_region, rg);
            check(resp_mem_type, e[6:5]);
            check(resp_shareable, e[4]);
            check({resp_inner_pol, resp_outer_pol}, e[3:0]);
            check(resp_in_order, e[6:5] == 2'h0);
            check(bus_inner_attr_sideband, {e[4], e[6:5], e[3:2]});
            check(bus_outer_attr_signals, e[6:5] == 2'h0 ? CACHE_SO : e[6:5] == 2'h1 ? CACHE_DEV :
                  e[1:0] == POL_WBWA ? CACHE_WBWA : CACHE_NC);
            if (!dm) check({resp_ap, resp_xn}, 4'hB);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        check(req_ready, 1'b0);
        check(resp_valid, 1'b0);
        check(drain_req, 1'b0);
        check(bus_inner_attr_sideband, 5'h00);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        acc(32'h0000_1000, 1'b1, 1'b0, 0, 1'b1, 1'b0, 4'h0, 7'h00);
        set_reg(1, mk(32'h0000_1000, 5'h0B, 8'h01, 5'h07, 1'b1));
        acc(32'h0000_1400, 1'b0, 1'b0, 0, 1'b0, 1'b0, 4'h1, 7'h55);
        acc(32'h0000_1010, 1'b1, 1'b0, 0, 1'b1, 1'b0, 4'h0, 7'h00);
        set_reg(3, mk(32'h0000_1200, 5'h08, 8'h00, 5'h00, 1'b0));
        acc(32'h0000_1300, 1'b0, 1'b1, 0, 1'b0, 1'b0, 4'h3, 7'h10);
        set_reg(5, mk(32'h0000_1400, 5'h08, 8'h01, 5'h08, 1'b1));
        acc(32'h0000_1410, 1'b0, 1'b0, 0, 1'b0, 1'b0, 4'h1, 7'h55);
        acc(32'h0000_1450, 1'b0, 1'b0, 0, 1'b0, 1'b0, 4'h5, 7'h20);
        set_reg(0, mk(32'h0000_0000, 5'h1F, 8'h00, 5'h04, 1'b0));
        acc(32'h8000_0000, 1'b1, 1'b0, 0, 1'b0, 1'b0, 4'h0, 7'h40);
        set_reg(0, '0);
        @(posedge clk_sys);
        scw <= 32'h0002_0001;
        acc(32'h8000_0000, 1'b0, 1'b1, 0, 1'b0, 1'b1, 4'h0, 7'h30);
        acc(32'h8000_0000, 1'b0, 1'b0, 0, 1'b1, 1'b0, 4'h0, 7'h00);
        codes = '{5'h00, 5'h01, 5'h04, 5'h07, 5'h08, 5'h14, 5'h19, 5'h02};
        exps = '{7'h10, 7'h30, 7'h50, 7'h55, 7'h20, 7'h51, 7'h54, 7'h10};
        for (int i = 0; i < 8; i++) begin
            set_reg(2, mk(32'h0000_2000, 5'h08, 8'h00, codes[i], 1'b1));
            acc(32'h0000_2010, 1'b1, 1'b1, 0, 1'b0, 1'b0, 4'h2, exps[i]);
        end
        set_reg(2, mk(32'h0000_2000, 5'h08, 8'h00, 5'h00, 1'b1));
        tcm_enable <= 1'b1;
        acc(32'h0000_2010, 1'b0, 1'b1, 0, 1'b0, 1'b0, 4'h2, 7'h40);
        check(resp_tcm, 1'b1);
        tcm_enable <= 1'b0;
        set_reg(2, mk(32'h0000_2000, 5'h08, 8'h00, 5'h08, 1'b1));
        fork
            acc(32'h0000_2010, 1'b0, 1'b1, 4, 1'b0, 1'b0, 4'h2, 7'h20);
            begin
                repeat (3) @(posedge clk_sys);
                #1;
                check({drain_req, req_ready, irq_latency_ext}, 3'h5);
            end
        join
        acc(32'h0000_2010, 1'b1, 1'b1, 3, 1'b0, 1'b0, 4'h2, 7'h20);
        print_verdict();
    end
endmodule
